// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic                       clk = 1'h0;
    logic                       sys_rst = 1'h1;
    logic [6:0]                 reg_addr = 7'h00;
    logic                       reg_wr = 1'h0;
    agc_timing_pkg::reg_byte_t  reg_wdata = 8'h00;
    logic                       reg_rd = 1'h0;
    agc_timing_pkg::reg_byte_t  reg_rdata_r;
    agc_timing_pkg::time_ms_t   legacy_attack_ms = 16'h1234;
    agc_timing_pkg::time_ms_t   legacy_decay_ms = 16'h0321;
    agc_timing_pkg::div_code_t  adc_clock_divide_ratio = 4'ha;
    agc_timing_pkg::div_code_t  dac_clock_divide_ratio = 4'ha;
    agc_timing_pkg::time_ms_t   attack_time_r;
    agc_timing_pkg::time_ms_t   decay_time_r;
    logic                       attack_from_reg_r;
    logic                       decay_from_reg_r;
    logic                       div_mismatch_r;
    int                         err_count = 0;
    int                         checked = 0;
    logic [15:0]                atk [4] = '{16'h0007, 16'h0008,
                                            16'h000a, 16'h000b};
    logic [15:0]                dcy [4] = '{16'h0032, 16'h0096,
                                            16'h00fa, 16'h015e};

    always #2 clk = ~clk;

    right_agc_attack_decay_timing dut (
        .clk                    (clk),
        .sys_rst                (sys_rst),
        .reg_addr               (reg_addr),
        .reg_wr                 (reg_wr),
        .reg_wdata              (reg_wdata),
        .reg_rd                 (reg_rd),
        .reg_rdata_r            (reg_rdata_r),
        .legacy_attack_ms       (legacy_attack_ms),
        .legacy_decay_ms        (legacy_decay_ms),
        .adc_clock_divide_ratio (adc_clock_divide_ratio),
        .dac_clock_divide_ratio (dac_clock_divide_ratio),
        .attack_time_r          (attack_time_r),
        .decay_time_r           (decay_time_r),
        .attack_from_reg_r      (attack_from_reg_r),
        .decay_from_reg_r       (decay_from_reg_r),
        .div_mismatch_r         (div_mismatch_r)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'h1;
        @(negedge clk);
        reg_wr    = 1'h0;
        // idle edge so a following strobe is a fresh pulse
        @(negedge clk);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd   = 1'h1;
        @(negedge clk);
        reg_rd   = 1'h0;
        @(negedge clk);
        // read data holds until the next read strobe
        chk({8'h00, reg_rdata_r}, {8'h00, exp});
    endtask

    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    function automatic logic [15:0] ceil_ms(input logic [3:0] c);
        case (c)
            4'h0: ceil_ms = 16'h0fa0;
            4'h1: ceil_ms = 16'h15e0;
            4'h2: ceil_ms = 16'h1f40;
            4'h3: ceil_ms = 16'h2580;
            4'h4, 4'h5: ceil_ms = 16'h2bc0;
            4'h6, 4'h7: ceil_ms = 16'h3e80;
            4'h8: ceil_ms = 16'h4b00;
            default: ceil_ms = 16'h5780;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        rd(7'h69, 8'h00);
        rd(7'h6a, 8'h00);
        chk(attack_time_r, legacy_attack_ms);
        chk(decay_time_r, legacy_decay_ms);
        chk({15'h0000, attack_from_reg_r}, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_fields();
        logic [15:0] t;
        for (int b = 0; b < 4; b++) begin
            for (int m = 0; m < 8; m++) begin
                wr(7'h69, {1'h1, b[1:0], m[2:0], 2'h0});
                wr(7'h6a, {1'h1, b[1:0], m[2:0], 2'h0});
                settle();
                chk(attack_time_r, atk[b] << m);
                t = dcy[b] << m;
                if (t > 16'h5780) t = 16'h5780;
                chk(decay_time_r, t);
                chk({14'h0000, attack_from_reg_r, decay_from_reg_r},
                    16'h0003);
            end
        end
        $display("test fields done");
    endtask

    task automatic test_ceiling();
        wr(7'h6a, 8'hfc);
        for (int c = 0; c < 16; c++) begin
            adc_clock_divide_ratio = c[3:0];
            dac_clock_divide_ratio = c[3:0];
            settle();
            chk(decay_time_r, ceil_ms(c[3:0]));
            chk({15'h0000, div_mismatch_r}, 16'h0000);
        end
        dac_clock_divide_ratio = 4'h3;
        settle();
        chk({15'h0000, div_mismatch_r}, 16'h0001);
        wr(7'h6a, 8'h00);
        legacy_decay_ms = 16'hffff;
        adc_clock_divide_ratio = 4'h0;
        dac_clock_divide_ratio = 4'h0;
        settle();
        chk(decay_time_r, 16'h0fa0);
        legacy_decay_ms = 16'h0321;
        adc_clock_divide_ratio = 4'ha;
        dac_clock_divide_ratio = 4'ha;
        $display("test ceiling done");
    endtask

    task automatic test_regs();
        wr(7'h69, 8'h7c);
        rd(7'h69, 8'h7c);
        legacy_attack_ms = 16'h0042;
        settle();
        chk(attack_time_r, 16'h0042);
        chk({15'h0000, attack_from_reg_r}, 16'h0000);
        wr(7'h55, 8'hff);
        rd(7'h55, 8'h00);
        rd(7'h69, 8'h7c);
        rd(7'h6a, 8'h00);
        wr(7'h6a, 8'h9c);
        sys_rst = 1'h1;
        @(negedge clk);
        sys_rst = 1'h0;
        @(negedge clk);
        rd(7'h6a, 8'h00);
        rd(7'h69, 8'h00);
        settle();
        chk(decay_time_r, legacy_decay_ms);
        $display("test registers done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (3) @(negedge clk);
        sys_rst = 1'h0;
        @(negedge clk);
        test_reset();
        test_fields();
        test_ceiling();
        test_regs();
        wrap_up();
    end
endmodule

// ---- verilog/agc_time_scale.sv ----
`timescale 1ns/1ns
module agc_time_scale #(
    parameter agc_timing_pkg::time_ms_t BASE0 = 16'h0001,
    parameter agc_timing_pkg::time_ms_t BASE1 = 16'h0001,
    parameter agc_timing_pkg::time_ms_t BASE2 = 16'h0001,
    parameter agc_timing_pkg::time_ms_t BASE3 = 16'h0001
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [1:0]               base_code,
    input  wire logic [2:0]               mult_code,
    output agc_timing_pkg::time_ms_t      scaled_r
);
    agc_timing_pkg::time_ms_t base_ms;
    agc_timing_pkg::time_ms_t scaled_nxt;

    assign base_ms = (base_code == 2'h0) ? BASE0 :
                     (base_code == 2'h1) ? BASE1 :
                     (base_code == 2'h2) ? BASE2 : BASE3;
    // baseline times power of two
    assign scaled_nxt = 16'(base_ms << mult_code);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scaled_r <= 16'h0000;
        end else begin
            scaled_r <= scaled_nxt;
        end
    end
endmodule

// ---- verilog/agc_timing_defines.svh ----
`ifndef AGC_TIMING_DEFINES_SVH
`define AGC_TIMING_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ATK_REG_ADDR   7'h69
`define DCY_REG_ADDR   7'h6a
`define TIMING_RST_VAL 8'h00
`define UNMAPPED_RD    8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SRC_BIT        7
`define BASE_HI        6
`define BASE_LO        5
`define MULT_HI        4
`define MULT_LO        2

// ----------------------------------------------------------------
// baseline times in ms
// ----------------------------------------------------------------
`define ATK_BASE0_MS   16'h0007
`define ATK_BASE1_MS   16'h0008
`define ATK_BASE2_MS   16'h000a
`define ATK_BASE3_MS   16'h000b
`define DCY_BASE0_MS   16'h0032
`define DCY_BASE1_MS   16'h0096
`define DCY_BASE2_MS   16'h00fa
`define DCY_BASE3_MS   16'h015e

// ----------------------------------------------------------------
// adc divide ratio codes and decay ceilings in ms
// ----------------------------------------------------------------
`define DIV_1_0        4'h0
`define DIV_1_5        4'h1
`define DIV_2_0        4'h2
`define DIV_2_5        4'h3
`define DIV_3_0        4'h4
`define DIV_3_5        4'h5
`define DIV_4_0        4'h6
`define DIV_4_5        4'h7
`define DIV_5_0        4'h8
`define DIV_5_5        4'h9
`define DIV_6_0        4'ha
`define CAP_1_0_MS     16'h0fa0
`define CAP_1_5_MS     16'h15e0
`define CAP_2_0_MS     16'h1f40
`define CAP_2_5_MS     16'h2580
`define CAP_3_X_MS     16'h2bc0
`define CAP_4_X_MS     16'h3e80
`define CAP_5_0_MS     16'h4b00
`define CAP_5_X_MS     16'h5780

`endif

// ---- verilog/agc_timing_pkg.sv ----
package agc_timing_pkg;
    typedef logic [15:0] time_ms_t;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [3:0]  div_code_t;
endpackage

// ---- verilog/right_agc_attack_decay_timing.sv ----
// Notes on behaviour
// - attack source bit 0 uses legacy attack time, 1 uses this register
// - attack baseline codes 00..11 give 7, 8, 10, 11 ms
// - attack multiplier code n scales baseline by two to the n
// - decay source bit 0 uses legacy decay time, 1 uses this register
// - decay baseline codes 00..11 give 50, 150, 250, 350 ms
// - decay multiplier code n scales baseline by two to the n
// - decay time capped by a ceiling set by adc divide ratio
`timescale 1ns/1ns
`include "agc_timing_defines.svh"
module right_agc_attack_decay_timing (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic [6:0]                reg_addr,
    input  wire logic                      reg_wr,
    input  wire agc_timing_pkg::reg_byte_t reg_wdata,
    input  wire logic                      reg_rd,
    output agc_timing_pkg::reg_byte_t      reg_rdata_r,
    input  wire agc_timing_pkg::time_ms_t  legacy_attack_ms,
    input  wire agc_timing_pkg::time_ms_t  legacy_decay_ms,
    input  wire agc_timing_pkg::div_code_t adc_clock_divide_ratio,
    input  wire agc_timing_pkg::div_code_t dac_clock_divide_ratio,
    output agc_timing_pkg::time_ms_t       attack_time_r,
    output agc_timing_pkg::time_ms_t       decay_time_r,
    output logic                           attack_from_reg_r,
    output logic                           decay_from_reg_r,
    output logic                           div_mismatch_r
);
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    agc_timing_pkg::reg_byte_t atk_r;
    agc_timing_pkg::reg_byte_t dcy_r;
    agc_timing_pkg::reg_byte_t rdata_nxt;
    logic                      atk_hit;
    logic                      dcy_hit;
    logic                      atk_wr;
    logic                      dcy_wr;

    assign atk_hit = (reg_addr == `ATK_REG_ADDR);
    assign dcy_hit = (reg_addr == `DCY_REG_ADDR);
    assign atk_wr  = reg_wr & atk_hit;
    assign dcy_wr  = reg_wr & dcy_hit;
    assign rdata_nxt = atk_hit ? atk_r :
                       dcy_hit ? dcy_r : `UNMAPPED_RD;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            atk_r <= `TIMING_RST_VAL;
            dcy_r <= `TIMING_RST_VAL;
        end else begin
            if (atk_wr) begin
                atk_r <= reg_wdata;
            end
            if (dcy_wr) begin
                dcy_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // scaled times, low reserved bits take no part
    // ------------------------------------------------------------
    agc_timing_pkg::time_ms_t atk_scaled;
    agc_timing_pkg::time_ms_t dcy_scaled;

    agc_time_scale #(
        .BASE0 (`ATK_BASE0_MS),
        .BASE1 (`ATK_BASE1_MS),
        .BASE2 (`ATK_BASE2_MS),
        .BASE3 (`ATK_BASE3_MS)
    ) u_atk_scale (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .base_code (atk_r[`BASE_HI:`BASE_LO]),
        .mult_code (atk_r[`MULT_HI:`MULT_LO]),
        .scaled_r  (atk_scaled)
    );

    agc_time_scale #(
        .BASE0 (`DCY_BASE0_MS),
        .BASE1 (`DCY_BASE1_MS),
        .BASE2 (`DCY_BASE2_MS),
        .BASE3 (`DCY_BASE3_MS)
    ) u_dcy_scale (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .base_code (dcy_r[`BASE_HI:`BASE_LO]),
        .mult_code (dcy_r[`MULT_HI:`MULT_LO]),
        .scaled_r  (dcy_scaled)
    );

    // ------------------------------------------------------------
    // source select and decay ceiling
    // ------------------------------------------------------------
    agc_timing_pkg::time_ms_t  cap_ms;
    agc_timing_pkg::time_ms_t  atk_nxt;
    agc_timing_pkg::time_ms_t  dcy_req;
    agc_timing_pkg::time_ms_t  dcy_nxt;
    agc_timing_pkg::div_code_t adc_div;

    assign adc_div = adc_clock_divide_ratio;
    // unlisted codes take the largest ceiling
    assign cap_ms =
        (adc_div == `DIV_1_0) ? `CAP_1_0_MS :
        (adc_div == `DIV_1_5) ? `CAP_1_5_MS :
        (adc_div == `DIV_2_0) ? `CAP_2_0_MS :
        (adc_div == `DIV_2_5) ? `CAP_2_5_MS :
        (adc_div == `DIV_3_0) ? `CAP_3_X_MS :
        (adc_div == `DIV_3_5) ? `CAP_3_X_MS :
        (adc_div == `DIV_4_0) ? `CAP_4_X_MS :
        (adc_div == `DIV_4_5) ? `CAP_4_X_MS :
        (adc_div == `DIV_5_0) ? `CAP_5_0_MS : `CAP_5_X_MS;

    assign atk_nxt = atk_r[`SRC_BIT] ? atk_scaled : legacy_attack_ms;
    assign dcy_req = dcy_r[`SRC_BIT] ? dcy_scaled : legacy_decay_ms;
    assign dcy_nxt = (dcy_req > cap_ms) ? cap_ms : dcy_req;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            attack_time_r     <= 16'h0000;
            decay_time_r      <= 16'h0000;
            attack_from_reg_r <= 1'h0;
            decay_from_reg_r  <= 1'h0;
            div_mismatch_r    <= 1'h0;
        end else begin
            attack_time_r     <= atk_nxt;
            decay_time_r      <= dcy_nxt;
            attack_from_reg_r <= atk_r[`SRC_BIT];
            decay_from_reg_r  <= dcy_r[`SRC_BIT];
            // flags software breaking ratio matching
            div_mismatch_r    <= (dac_clock_divide_ratio != adc_div);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    agc_timing_pkg::time_ms_t exp_atk;
    agc_timing_pkg::time_ms_t exp_dcy;
    agc_timing_pkg::time_ms_t atk_base_chk;
    agc_timing_pkg::time_ms_t dcy_base_chk;
    logic                     wr_seen_r;

    assign atk_base_chk = (atk_r[6:5] == 2'h0) ? 16'h0007 :
                          (atk_r[6:5] == 2'h1) ? 16'h0008 :
                          (atk_r[6:5] == 2'h2) ? 16'h000a : 16'h000b;
    assign dcy_base_chk = (dcy_r[6:5] == 2'h0) ? 16'h0032 :
                          (dcy_r[6:5] == 2'h1) ? 16'h0096 :
                          (dcy_r[6:5] == 2'h2) ? 16'h00fa : 16'h015e;
    assign exp_atk = 16'(atk_base_chk << atk_r[4:2]);
    assign exp_dcy = 16'(dcy_base_chk << dcy_r[4:2]);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_seen_r <= 1'h0;
        end else if (atk_wr | dcy_wr) begin
            wr_seen_r <= 1'h1;
        end
    end

    property p_atk_legacy;
        @(posedge clk) disable iff (sys_rst)
        !atk_r[7] |=> attack_time_r == $past(legacy_attack_ms);
    endproperty
    a_atk_legacy: assert property (p_atk_legacy)
        else $error("attack not taken from legacy source");

    property p_atk_base;
        @(posedge clk) disable iff (sys_rst)
        (atk_r[7:2] == 6'h20) && $stable(atk_r) |=>
            attack_time_r == 16'h0007;
    endproperty
    a_atk_base: assert property (p_atk_base)
        else $error("attack baseline code 00 not 7 ms");

    property p_atk_scale;
        @(posedge clk) disable iff (sys_rst)
        atk_r[7] && $stable(atk_r) |=> attack_time_r == $past(exp_atk);
    endproperty
    a_atk_scale: assert property (p_atk_scale)
        else $error("attack time not baseline times factor");

    property p_dcy_legacy;
        @(posedge clk) disable iff (sys_rst)
        !dcy_r[7] && (legacy_decay_ms <= cap_ms) |=>
            decay_time_r == $past(legacy_decay_ms);
    endproperty
    a_dcy_legacy: assert property (p_dcy_legacy)
        else $error("decay not taken from legacy source");

    property p_dcy_scale;
        @(posedge clk) disable iff (sys_rst)
        dcy_r[7] && $stable(dcy_r) && (exp_dcy <= cap_ms) |=>
            decay_time_r == $past(exp_dcy);
    endproperty
    a_dcy_scale: assert property (p_dcy_scale)
        else $error("decay time not baseline times factor");

    property p_dcy_cap;
        @(posedge clk) disable iff (sys_rst)
        (adc_div == 4'h0) && (dcy_req >= 16'h0fa0) |=>
            decay_time_r == 16'h0fa0;
    endproperty
    a_dcy_cap: assert property (p_dcy_cap)
        else $error("decay not capped at 4 s for ratio 1");

    property p_dcy_ceiling;
        @(posedge clk) disable iff (sys_rst)
        ##1 decay_time_r <= $past(cap_ms);
    endproperty
    a_dcy_ceiling: assert property (p_dcy_ceiling)
        else $error("decay time above ceiling");

    property p_reset_zero;
        @(posedge clk) disable iff (sys_rst)
        !wr_seen_r |-> (atk_r == 8'h00) && (dcy_r == 8'h00)
            && !attack_from_reg_r && !decay_from_reg_r;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("timing register not zero before first write");

    property p_mismatch;
        @(posedge clk) disable iff (sys_rst)
        (dac_clock_divide_ratio != adc_div) |=> div_mismatch_r;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("divide ratio mismatch not flagged");

    property p_readback;
        @(posedge clk) disable iff (sys_rst)
        reg_rd && dcy_hit |=> reg_rdata_r == $past(dcy_r);
    endproperty
    a_readback: assert property (p_readback)
        else $error("decay register read back wrong");
endmodule
